/* File: pkg/esp_consts.vh */
// Constants for the enhanced serial port: register offsets, fields, reset values, timing.
// Assumes a plain 8-bit register port with one-cycle read latency.
`ifndef ESP_CONSTS_VH
`define ESP_CONSTS_VH

// ==========================================================
// Register offsets
`define ESP_ADDR_W        3
`define ESP_OFF_CTRL      3'h0
`define ESP_OFF_BUF       3'h1
`define ESP_OFF_PWR       3'h2
`define ESP_OFF_ADDR      3'h3
`define ESP_OFF_MASK      3'h4
`define ESP_OFF_BAUD      3'h5

// ==========================================================
// Control register fields
`define ESP_CTRL_MODE_HI  7
`define ESP_CTRL_MODE_LO  6
`define ESP_CTRL_MPE      5
`define ESP_CTRL_REN      4
`define ESP_CTRL_TB8      3
`define ESP_CTRL_RB8      2
`define ESP_CTRL_TI       1
`define ESP_CTRL_RI       0

// Power control fields
`define ESP_PWR_DOUBLE    7
`define ESP_PWR_FEACC     6

// Baud source select field
`define ESP_BAUD_T2       0

// ==========================================================
// Reset values
`define ESP_CTRL_RST      8'h00
`define ESP_PWR_RST       8'h00
`define ESP_ADDR_RST      8'h00
`define ESP_MASK_RST      8'h00

// ==========================================================
// Timing: oscillator clocks per bit (shift, mode 2); timer overflows per bit (T1, T2)
`define ESP_SHIFT_DIV     12
`define ESP_M2_DIV        64
`define ESP_T1_DIV        32
`define ESP_T2_DIV        16

`endif

/* File: rtl/esp_serial_port.v */
// Enhanced serial port: shift mode and 10/11-bit asynchronous frames with address filter.
// Assumes CLK_SYS is the oscillator clock and timer overflow pulses arrive on CLK_SYS.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "esp_consts.vh"

module esp_serial_port
(
	// Clock and reset
	input  wire                   CLK_SYS,
	input  wire                   RST,
	// Register port
	input  wire [`ESP_ADDR_W-1:0] ADDR,
	input  wire [7:0]             WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output reg  [7:0]             RDATA,
	// Timer overflow pulses
	input  wire                   T1_OVF,
	input  wire                   T2_OVF,
	// Serial pins
	input  wire                   RXD_IN,
	output reg                    RXD_OUT,
	output reg                    RXD_OE,
	output reg                    TXD,
	// Interrupt request
	output reg                    SER_IRQ
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SHIFT = 2'h1;
	localparam ST_DONE = 2'h2;

	// ==========================================================
	// Registers
	reg [1:0] mode;
	reg       mpe;
	reg       ren;
	reg       tb8;
	reg       rb8;
	reg       ti;
	reg       ri;
	reg       fe;
	reg       pwr_double;
	reg       pwr_feacc;
	reg [5:0] pwr_other;
	reg [7:0] own_addr;
	reg [7:0] addr_mask;
	reg       baud_t2;
	reg [7:0] rx_buf;

	wire wr_ctrl = WR && (ADDR == `ESP_OFF_CTRL);
	wire wr_buf = WR && (ADDR == `ESP_OFF_BUF);
	wire wr_pwr = WR && (ADDR == `ESP_OFF_PWR);

	// ==========================================================
	// Pin synchroniser
	reg [2:0] rx_sync;
	always @(posedge CLK_SYS)
	begin
		if (RST)
			rx_sync <= 3'h7;
		else
			rx_sync <= {rx_sync[1:0], RXD_IN};
	end
	reg rx_pin;
	always @(posedge CLK_SYS)
	begin
		if (RST)
			rx_pin <= 1'b1;
		else if (rx_sync[1] == rx_sync[2])
			rx_pin <= rx_sync[2];
	end

	// ==========================================================
	// Baud ticks: 16x oversample tick for async modes
	reg [5:0] osc_cnt;
	reg       t1_half;
	reg       os_tick;
	reg [3:0] sh_cnt;
	reg       sh_tick;
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			osc_cnt <= 6'h00;
			t1_half <= 1'b0;
			os_tick <= 1'b0;
			sh_cnt <= 4'h0;
			sh_tick <= 1'b0;
		end
		else
		begin
			os_tick <= 1'b0;
			if (mode == 2'h2)
			begin
				// Mode 2: 64 or 32 osc clocks per bit, 16 ticks per bit
				if (osc_cnt >= (pwr_double ? 6'h01 : 6'h03))
				begin
					osc_cnt <= 6'h00;
					os_tick <= 1'b1;
				end
				else
					osc_cnt <= osc_cnt + 6'h01;
			end
			else if (baud_t2)
				os_tick <= T2_OVF;
			else if (T1_OVF)
			begin
				// Timer 1: halve unless double rate
				t1_half <= ~t1_half;
				os_tick <= pwr_double | t1_half;
			end
			sh_tick <= 1'b0;
			if (sh_cnt == 4'd`ESP_SHIFT_DIV - 4'h1)
			begin
				sh_cnt <= 4'h0;
				sh_tick <= 1'b1;
			end
			else
				sh_cnt <= sh_cnt + 4'h1;
		end
	end

	// ==========================================================
	// Transmitter
	reg [1:0]  tx_st;
	reg [10:0] tx_sr;
	reg [3:0]  tx_bits;
	reg [3:0]  tx_os;
	reg        tx_done;
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			tx_st <= ST_IDLE;
			tx_sr <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_os <= 4'h0;
			tx_done <= 1'b0;
			TXD <= 1'b1;
			RXD_OUT <= 1'b1;
			RXD_OE <= 1'b0;
		end
		else
		begin
			tx_done <= 1'b0;
			case (tx_st)
			ST_IDLE:
			begin
				TXD <= 1'b1;
				RXD_OE <= 1'b0;
				if (wr_buf)
				begin
					tx_st <= ST_SHIFT;
					tx_os <= 4'h0;
					if (mode == 2'h0)
					begin
						tx_sr <= {3'h7, WDATA};
						tx_bits <= 4'd8;
					end
					else if (mode == 2'h1)
					begin
						tx_sr <= {1'b1, 1'b1, WDATA, 1'b0};
						tx_bits <= 4'd10;
					end
					else
					begin
						tx_sr <= {1'b1, tb8, WDATA, 1'b0};
						tx_bits <= 4'd11;
					end
				end
			end
			ST_SHIFT:
			begin
				if (mode == 2'h0)
				begin
					// Shift mode: data on RXD, clock low for first half of bit
					if (sh_tick)
					begin
						RXD_OE <= 1'b1;
						RXD_OUT <= tx_sr[0];
						TXD <= 1'b0;
						tx_os <= 4'h1;
					end
					else if (tx_os == 4'h1 && sh_cnt == 4'd6)
					begin
						TXD <= 1'b1;
						tx_os <= 4'h0;
						tx_sr <= {1'b1, tx_sr[10:1]};
						tx_bits <= tx_bits - 4'h1;
						if (tx_bits == 4'h1)
							tx_st <= ST_DONE;
					end
				end
				else if (os_tick)
				begin
					TXD <= tx_sr[0];
					tx_os <= tx_os + 4'h1;
					if (tx_os == 4'hf)
					begin
						tx_sr <= {1'b1, tx_sr[10:1]};
						tx_bits <= tx_bits - 4'h1;
						if (tx_bits == 4'h1)
							tx_st <= ST_DONE;
					end
				end
			end
			ST_DONE:
			begin
				tx_done <= 1'b1;
				tx_st <= ST_IDLE;
			end
			default: tx_st <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receiver
	function addr_match;
		input [7:0] data;
		input [7:0] adr;
		input [7:0] msk;
		begin
			// Given address on masked bits, or broadcast address
			addr_match = (((data ^ adr) & msk) == 8'h00) ||
				(((data ^ (adr | msk)) & (adr | msk)) == 8'h00);
		end
	endfunction

	reg [1:0] rx_st;
	reg [9:0] rx_sr;
	reg [3:0] rx_bits;
	reg [3:0] rx_os;
	reg       rx_fin;
	reg       rx_sh_clk;
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			rx_st <= ST_IDLE;
			rx_sr <= 10'h000;
			rx_bits <= 4'h0;
			rx_os <= 4'h0;
			rx_fin <= 1'b0;
			rx_sh_clk <= 1'b0;
		end
		else
		begin
			rx_fin <= 1'b0;
			case (rx_st)
			ST_IDLE:
			begin
				rx_os <= 4'h0;
				rx_sh_clk <= 1'b0;
				// Cleared here, after the finished frame has been copied out
				rx_sr <= 10'h000;
				if (ren && mode == 2'h0 && !ri && tx_st == ST_IDLE)
				begin
					rx_st <= ST_SHIFT;
					rx_bits <= 4'd8;
				end
				else if (ren && mode != 2'h0 && !rx_pin)
				begin
					rx_st <= ST_SHIFT;
					rx_bits <= (mode == 2'h1) ? 4'd10 : 4'd11;
				end
			end
			ST_SHIFT:
			begin
				if (mode == 2'h0)
				begin
					// Sample data at rising shift clock
					if (sh_tick)
						rx_sh_clk <= 1'b1;
					else if (rx_sh_clk && sh_cnt == 4'd6)
					begin
						rx_sh_clk <= 1'b0;
						rx_sr <= {rx_pin, rx_sr[9:1]};
						rx_bits <= rx_bits - 4'h1;
						if (rx_bits == 4'h1)
							rx_st <= ST_DONE;
					end
				end
				else if (os_tick)
				begin
					rx_os <= rx_os + 4'h1;
					if (rx_os == 4'h7)
					begin
						if (rx_bits > 4'd9 - {3'h0, mode[1]} && rx_pin && rx_sr == 10'h000
							&& rx_bits == (mode == 2'h1 ? 4'd10 : 4'd11))
							rx_st <= ST_IDLE; // False start bit
						else
						begin
							rx_sr <= {rx_pin, rx_sr[9:1]};
							rx_bits <= rx_bits - 4'h1;
							if (rx_bits == 4'h1)
								rx_st <= ST_DONE;
						end
					end
				end
			end
			ST_DONE:
			begin
				rx_fin <= 1'b1;
				rx_st <= ST_IDLE;
			end
			default: rx_st <= ST_IDLE;
			endcase
		end
	end

	// Received frame fields, aligned by mode
	wire [7:0] rx_byte = (mode == 2'h0) ? rx_sr[9:2] : (mode == 2'h1) ? rx_sr[8:1] : rx_sr[7:0];
	wire       rx_stop = rx_sr[9];
	wire       rx_ninth = (mode == 2'h1) ? rx_sr[9] : rx_sr[8];
	wire       rx_hit = addr_match(rx_byte, own_addr, addr_mask);
	reg        rx_flag_set;
	always @*
	begin
		rx_flag_set = 1'b1;
		if (mpe && mode == 2'h1)
			rx_flag_set = rx_stop && rx_hit;
		else if (mpe && mode[1])
			rx_flag_set = rx_ninth && rx_hit;
	end

	// ==========================================================
	// Register file; hardware set wins over software clear
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			{mode, mpe, ren, tb8, rb8, ti, ri} <= `ESP_CTRL_RST;
			fe <= 1'b0;
			{pwr_double, pwr_feacc, pwr_other} <= `ESP_PWR_RST;
			own_addr <= `ESP_ADDR_RST;
			addr_mask <= `ESP_MASK_RST;
			baud_t2 <= 1'b0;
			rx_buf <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
			begin
				if (pwr_feacc)
					fe <= WDATA[`ESP_CTRL_MODE_HI];
				else
					mode[1] <= WDATA[`ESP_CTRL_MODE_HI];
				mode[0] <= WDATA[`ESP_CTRL_MODE_LO];
				mpe <= WDATA[`ESP_CTRL_MPE];
				ren <= WDATA[`ESP_CTRL_REN];
				tb8 <= WDATA[`ESP_CTRL_TB8];
				rb8 <= WDATA[`ESP_CTRL_RB8];
				ti <= WDATA[`ESP_CTRL_TI];
				ri <= WDATA[`ESP_CTRL_RI];
			end
			if (wr_pwr)
				{pwr_double, pwr_feacc, pwr_other} <= WDATA;
			if (WR && ADDR == `ESP_OFF_ADDR)
				own_addr <= WDATA;
			if (WR && ADDR == `ESP_OFF_MASK)
				addr_mask <= WDATA;
			if (WR && ADDR == `ESP_OFF_BAUD)
				baud_t2 <= WDATA[`ESP_BAUD_T2];
			if (tx_done)
				ti <= 1'b1;
			if (rx_fin)
			begin
				rx_buf <= rx_byte;
				if (mode != 2'h0)
					rb8 <= rx_ninth;
				if (mode != 2'h0 && !rx_stop)
					fe <= 1'b1;
				if (rx_flag_set)
					ri <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read data and interrupt output
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			RDATA <= 8'h00;
			SER_IRQ <= 1'b0;
		end
		else
		begin
			SER_IRQ <= ti | ri;
			if (RD)
				case (ADDR)
				`ESP_OFF_CTRL: RDATA <= {pwr_feacc ? fe : mode[1], mode[0], mpe, ren,
					tb8, rb8, ti, ri};
				`ESP_OFF_BUF: RDATA <= rx_buf;
				`ESP_OFF_PWR: RDATA <= {pwr_double, pwr_feacc, pwr_other};
				`ESP_OFF_ADDR: RDATA <= own_addr;
				`ESP_OFF_MASK: RDATA <= addr_mask;
				`ESP_OFF_BAUD: RDATA <= {7'h00, baud_t2};
				default: RDATA <= 8'h00;
				endcase
		end
	end

endmodule // esp_serial_port

/* File: verif/esp_serial_port_sva.sv */
// Checker for the serial port: register port, serial pins and interrupt line.
// Assumes a bind onto esp_serial_port; it sees only that module's ports.
`timescale 1ns/1ps
module esp_serial_port_sva
(
	// Clock and reset
	input wire       CLK_SYS,
	input wire       RST,
	// Register port
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	// Pins and interrupt
	input wire       TXD,
	input wire       RXD_OE,
	input wire       SER_IRQ
);
	// ==========================================
	// Shadow of mode, rate select and line state
	reg [1:0] mode;
	reg       fe_acc;
	reg       dbl;
	reg       seen;
	reg [9:0] low_cnt;
	always @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			mode    <= 2'b00;
			fe_acc  <= 1'b0;
			dbl     <= 1'b0;
			seen    <= 1'b0;
			low_cnt <= 10'h000;
		end
		else
		begin
			if (WR && ADDR == 3'h0)
				mode <= {fe_acc ? mode[1] : WDATA[7], WDATA[6]};
			if (WR && ADDR == 3'h2)
			begin
				fe_acc <= WDATA[6];
				dbl    <= WDATA[7];
			end
			seen    <= seen | (WR && ADDR <= 3'h1);
			low_cnt <= TXD ? 10'h000 : low_cnt + 10'h001;
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// ==========================================
	// Properties
	chk_reset_vals: assert property (disable iff (1'b0)
		RST |=> TXD && !RXD_OE && !SER_IRQ && RDATA == 8'h00)
		else $error("outputs not at reset values");
	chk_rdata_hold: assert property (!RD |=> $stable(RDATA))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (RD && ADDR > 3'h5 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	chk_addr_mask_rw: assert property (WR && (ADDR == 3'h3 || ADDR == 3'h4) ##1 !WR
		##1 RD && ADDR == $past(ADDR, 2) |=> RDATA == $past(WDATA, 3))
		else $error("address or mask readback wrong");
	chk_oe_mode_zero: assert property (RXD_OE |-> mode == 2'b00)
		else $error("data pin driven outside shift mode");
	chk_idle_before_use: assert property (!seen |-> TXD && !RXD_OE)
		else $error("serial pins active before any access");
	chk_m2_bit_time: assert property ($rose(TXD) && mode == 2'b10 |->
		(low_cnt & (dbl ? 10'd31 : 10'd63)) == 10'd0)
		else $error("mode 2 low run not whole bit times");
	chk_irq_soft_set: assert property (WR && ADDR == 3'h0 && WDATA[1] |-> ##2 SER_IRQ)
		else $error("interrupt missing after flag set");
	chk_irq_holds: assert property (SER_IRQ && !$past(WR && ADDR == 3'h0) |=> SER_IRQ)
		else $error("interrupt dropped without software");
endmodule // esp_serial_port_sva

/* File: verif/esp_peer.sv */
// Far-side serial peer that sends asynchronous frames into the receive pin.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ps
module esp_peer
(
	// Clock and line
	input  wire CLK_SYS,
	output reg  RXD_LINE
);
	initial RXD_LINE = 1'b1;
	// Bits go LSB first, each held clks cycles; the line idles high
	task send(input [10:0] bits, input integer n, input integer clks);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
			begin
				RXD_LINE <= bits[i];
				repeat (clks) @(posedge CLK_SYS);
			end
			RXD_LINE <= 1'b1;
		end
	endtask
endmodule // esp_peer

/* File: verif/esp_serial_port_test.sv */
// Testbench for the serial port: registers, shift and mode 2 transmit, mode 1 receive.
// Assumes the design header esp_consts.vh on the include path.
`timescale 1ns/1ps
module esp_serial_port_test;
	reg        clk = 1'b0;
	reg        rst;
	reg  [2:0] addr;
	reg  [7:0] wdata;
	reg        wr;
	reg        rd;
	wire [7:0] rdata;
	wire       rxd_in;
	wire       rxd_out;
	wire       rxd_oe;
	wire       txd;
	wire       ser_irq;
	integer    errors = 0;
	integer    samples_checked = 0;
	always #25 clk = ~clk;
	esp_serial_port dut_u (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .T1_OVF(1'b1), .T2_OVF(1'b1), .RXD_IN(rxd_in),
		.RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD(txd), .SER_IRQ(ser_irq));
	esp_peer peer_u (.CLK_SYS(clk), .RXD_LINE(rxd_in));
	// ==========================================
	// Shared tasks
	task end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input string name, input [8:0] seen, input [8:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr_reg(input [2:0] a, input [7:0] d);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd_reg(input [2:0] a, input [7:0] exp);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("read data", {1'b0, rdata}, {1'b0, exp});
		@(posedge clk);
	endtask
	function pick(input integer s);
		pick = (s == 0) ? txd : (s == 1) ? rxd_oe : ser_irq;
	endfunction
	task wait_on(input integer s, input v, input integer lim);
		integer n;
		n = 0;
		while (pick(s) !== v && n < lim)
		begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
		if (n >= lim)
		begin
			errors = errors + 1;
			end_sim;
		end
	endtask
	// ==========================================
	// Scenarios
	task t_regs;
		integer i;
		for (i = 0; i < 8; i = i + 1)
			rd_reg(i[2:0], 8'h00);
		wr_reg(3'h3, 8'h12);
		rd_reg(3'h3, 8'h12);
		wr_reg(3'h4, 8'hf0);
		rd_reg(3'h4, 8'hf0);
		wr_reg(3'h7, 8'h55);
		rd_reg(3'h7, 8'h00);
		wr_reg(3'h0, 8'h02);
		#1;
		check("irq set", {8'h00, ser_irq}, 9'h001);
		rd_reg(3'h0, 8'h02);
		wr_reg(3'h0, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		check("irq clear", {8'h00, ser_irq}, 9'h000);
		$display("test done: registers");
	endtask
	task t_tx0;
		integer i;
		time    t0;
		wr_reg(3'h1, 8'h5a);
		wait_on(1, 1'b1, 40);
		for (i = 0; i < 8; i = i + 1)
		begin
			wait_on(0, 1'b0, 40);
			wait_on(0, 1'b1, 40);
			if (i == 0)
				t0 = $time;
			check("shift data", {8'h00, rxd_out}, {8'h00, ((8'h5a >> i) & 8'h01) != 8'h00});
		end
		check("shift period", ($time - t0) / 50, 9'd84);
		wait_on(2, 1'b1, 60);
		wr_reg(3'h0, 8'h00);
		$display("test done: shift transmit");
	endtask
	task t_tx2(input dbl);
		integer     i;
		integer     p;
		reg  [10:0] fr;
		p  = dbl ? 32 : 64;
		fr = {2'b11, 8'ha5, 1'b0};
		wr_reg(3'h2, {dbl, 7'h00});
		wr_reg(3'h0, 8'h88);
		wr_reg(3'h1, 8'ha5);
		wait_on(0, 1'b0, 200);
		repeat (p / 2) @(posedge clk);
		for (i = 0; i < 11; i = i + 1)
		begin
			check("mode 2 bit", {8'h00, txd}, {8'h00, fr[i]});
			repeat (p) @(posedge clk);
		end
		wait_on(2, 1'b1, 200);
		wr_reg(3'h0, 8'h00);
		$display("test done: mode 2 transmit");
	endtask
	task rx_frame(input [9:0] fr, input [7:0] ctl, input [7:0] buf_exp, input [7:0] clr);
		peer_u.send({1'b1, fr}, 10, 16);
		repeat (4) @(posedge clk);
		rd_reg(3'h0, ctl);
		rd_reg(3'h1, buf_exp);
		wr_reg(3'h0, clr);
	endtask
	task t_rx1;
		wr_reg(3'h2, 8'h40);
		wr_reg(3'h5, 8'h01);
		wr_reg(3'h3, 8'h12);
		wr_reg(3'h4, 8'hff);
		wr_reg(3'h0, 8'h70);
		rx_frame({1'b1, 8'h34, 1'b0}, 8'h74, 8'h34, 8'h70);
		rx_frame({1'b1, 8'h12, 1'b0}, 8'h75, 8'h12, 8'h70);
		rx_frame({1'b0, 8'h12, 1'b0}, 8'hf0, 8'h12, 8'hf0);
		rx_frame({1'b1, 8'h12, 1'b0}, 8'hf5, 8'h12, 8'h70);
		// Timer 1 source at double rate: one tick per overflow
		wr_reg(3'h5, 8'h00);
		wr_reg(3'h2, 8'hc0);
		rx_frame({1'b1, 8'h12, 1'b0}, 8'h75, 8'h12, 8'h60);
		rx_frame({1'b1, 8'h55, 1'b0}, 8'h60, 8'h12, 8'h60);
		$display("test done: mode 1 receive");
	endtask
	initial
	begin
		rst   = 1'b1;
		wr    = 1'b0;
		rd    = 1'b0;
		addr  = 3'h0;
		wdata = 8'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_regs;
		t_tx0;
		t_tx2(1'b0);
		t_tx2(1'b1);
		t_rx1;
		end_sim;
	end
endmodule // esp_serial_port_test
bind esp_serial_port esp_serial_port_sva chk_u (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD(TXD), .RXD_OE(RXD_OE),
	.SER_IRQ(SER_IRQ));
